// >>> crf_map.svh
// constants for the cpu core register file
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
// ----------------------------------------
// data-space mirror addresses
// ----------------------------------------
`define CRF_ADDR_PTR_FIRST  8'h80
`define CRF_ADDR_PTR_SECOND 8'h81
`define CRF_ADDR_SD_FIRST   8'h82
`define CRF_ADDR_SD_SECOND  8'h83
`define CRF_ADDR_ACC        8'hFF
// ----------------------------------------
// widths, reset values and stack sizing
// ----------------------------------------
`define CRF_PC_W            12
`define CRF_BANK_W          4
`define CRF_REG_RESET       8'h00
`define CRF_PC_RESET        12'hFFE
`define CRF_STACK_LEVELS    6
`define CRF_DEPTH_FULL      3'h6
`define CRF_DEPTH_EMPTY     3'h0
`endif

// >>> crf_pkg.sv
// types for the cpu core register file
package crf_pkg;
  // program counter update source
  typedef enum logic [2:0] {
    PC_INCR             = 3'b000,
    PC_JUMP_ABSOLUTE    = 3'b001,
    PC_CALL             = 3'b010,
    PC_BRANCH           = 3'b011,
    PC_IRQ              = 3'b100,
    PC_SUBROUTINE_EXIT  = 3'b101,
    PC_INTERRUPT_EXIT   = 3'b110,
    PC_HOLD             = 3'b111
  } crf_pc_op_t;
  // execution context selecting the flag pair
  typedef enum logic [1:0] {
    CTX_NORMAL = 2'b00,
    CTX_INT    = 2'b01,
    CTX_NMI    = 2'b10
  } crf_ctx_t;
endpackage : crf_pkg

// >>> crf_core_regs.sv
// programmer-visible registers, flags, pc and return stack of the cpu core
// Notes on behaviour
// - 8-bit accumulator, mirrored at data address FFh
// - pointer registers mirrored at 80h and 81h
// - short-direct registers mirrored at 82h and 83h
// - selected pointer gives indirect operand address
// - 12-bit program counter reaches 4096 bytes
// - bank switch register extends program space
// - relative branch adds signed offset to pc
// - pc loaded per event, held on PC_HOLD, else incremented
// - three carry/zero pairs, one per context
// - interrupt entry switches pair; exit restores previous, only two levels kept
// - pairs retained, used only in own context
// - carry from arithmetic, bit test; feeds rotate
// - zero flag tracks latest result equals zero
// - reset starts in nmi context
// - six-level 12-bit hardware return stack
// - push shifts deeper, pc into level one
// - pop moves level one to pc, shifts up
// - beyond six nestings stack stays deepest
// - return on empty stack leaves it, continues
// - reset clears stack, pc to 0FFEh
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_core_regs (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // data-space bus
  input  wire logic [7:0]                 dsAddr,
  input  wire logic                       dsWrEn,
  input  wire logic [7:0]                 dsWrData,
  input  wire logic                       dsRdEn,
  output logic                            dsHit,
  output logic      [7:0]                 dsRdData,
  // alu write-back to accumulator
  input  wire logic                       accWrEn,
  input  wire logic [7:0]                 accWrData,
  output logic      [7:0]                 accValue,
  // indirect addressing
  input  wire logic                       indSel,
  output logic      [7:0]                 indAddr,
  // program counter control
  input  wire crf_pkg::crf_pc_op_t        pcOp,
  input  wire logic [`CRF_PC_W-1:0]       pcTarget,
  input  wire logic [7:0]                 branchOffset,
  input  wire logic [`CRF_PC_W-1:0]       irqVector,
  input  wire logic                       irqIsNmi,
  output logic      [`CRF_PC_W-1:0]       pcValue,
  // program bank switch
  input  wire logic                       bankWrEn,
  input  wire logic [`CRF_BANK_W-1:0]     bankWrData,
  output logic      [`CRF_BANK_W-1:0]     progBank,
  // flag update from the alu
  input  wire logic                       carryWe,
  input  wire logic                       carryIn,
  input  wire logic                       zeroWe,
  input  wire logic                       zeroIn,
  output logic                            carryOut,
  output logic                            zeroOut,
  output crf_pkg::crf_ctx_t               ctxValue,
  output logic      [2:0]                 stackDepth
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0]               acc_reg, ptrFirst_reg, ptrSecond_reg, sdFirst_reg, sdSecond_reg;
  logic [`CRF_PC_W-1:0]     pc_reg, pc_next;
  logic [`CRF_BANK_W-1:0]   bank_reg;
  logic [`CRF_PC_W-1:0]     stack_reg [`CRF_STACK_LEVELS];
  logic [2:0]               depth_reg;
  crf_pkg::crf_ctx_t        ctx_reg, ctxPrev1_reg, ctxPrev2_reg;
  logic carryNormal_reg, zeroNormal_reg, carryInterrupt_reg, zeroInterrupt_reg, carryNmi_reg, zeroNmi_reg;
  logic [7:0]               rd_next;
  logic                     doPush, doPop;

  assign doPush = (pcOp == crf_pkg::PC_CALL) || (pcOp == crf_pkg::PC_IRQ);
  assign doPop  = (pcOp == crf_pkg::PC_SUBROUTINE_EXIT) || (pcOp == crf_pkg::PC_INTERRUPT_EXIT);

  // ----------------------------------------
  // data-space mirror
  // ----------------------------------------
  // address decode of the mirrored core registers
  always_comb begin
    dsHit   = 1'b1;
    rd_next = 8'h00;
    unique case (dsAddr)
      `CRF_ADDR_PTR_FIRST:  rd_next = ptrFirst_reg;
      `CRF_ADDR_PTR_SECOND: rd_next = ptrSecond_reg;
      `CRF_ADDR_SD_FIRST:   rd_next = sdFirst_reg;
      `CRF_ADDR_SD_SECOND:  rd_next = sdSecond_reg;
      `CRF_ADDR_ACC:        rd_next = acc_reg;
      default:              dsHit   = 1'b0;
    endcase
  end

  // registered read data, zero when not hit
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dsRdData <= 8'h00;
    end else if (dsRdEn) begin
      dsRdData <= rd_next;
    end
  end

  // accumulator; alu write-back wins over a bus write
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc_reg <= `CRF_REG_RESET;
    end else if (accWrEn) begin
      acc_reg <= accWrData;
    end else if (dsWrEn && dsAddr == `CRF_ADDR_ACC) begin
      acc_reg <= dsWrData;
    end
  end

  // pointer and short-direct registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ptrFirst_reg  <= `CRF_REG_RESET;
      ptrSecond_reg <= `CRF_REG_RESET;
      sdFirst_reg   <= `CRF_REG_RESET;
      sdSecond_reg  <= `CRF_REG_RESET;
    end else if (dsWrEn) begin
      if (dsAddr == `CRF_ADDR_PTR_FIRST)  ptrFirst_reg  <= dsWrData;
      if (dsAddr == `CRF_ADDR_PTR_SECOND) ptrSecond_reg <= dsWrData;
      if (dsAddr == `CRF_ADDR_SD_FIRST)   sdFirst_reg   <= dsWrData;
      if (dsAddr == `CRF_ADDR_SD_SECOND)  sdSecond_reg  <= dsWrData;
    end
  end

  assign accValue = acc_reg;
  assign indAddr  = indSel ? ptrSecond_reg : ptrFirst_reg;

  // ----------------------------------------
  // program counter and bank
  // ----------------------------------------
  // next pc by event
  always_comb begin
    pc_next = 12'(pc_reg + 12'h001);
    unique case (pcOp)
      crf_pkg::PC_INCR:          pc_next = 12'(pc_reg + 12'h001);
      crf_pkg::PC_JUMP_ABSOLUTE: pc_next = pcTarget;
      crf_pkg::PC_CALL:          pc_next = pcTarget;
      crf_pkg::PC_BRANCH:        pc_next = 12'(pc_reg + {{4{branchOffset[7]}}, branchOffset});
      crf_pkg::PC_IRQ:           pc_next = irqVector;
      crf_pkg::PC_SUBROUTINE_EXIT,
      crf_pkg::PC_INTERRUPT_EXIT:
        pc_next = (depth_reg == `CRF_DEPTH_EMPTY) ? 12'(pc_reg + 12'h001) : stack_reg[0];
      crf_pkg::PC_HOLD:          pc_next = pc_reg;
    endcase
  end

  // pc register, reset vector on reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc_reg <= `CRF_PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // bank switch register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bank_reg <= '0;
    end else if (bankWrEn) begin
      bank_reg <= bankWrData;
    end
  end

  assign pcValue  = pc_reg;
  assign progBank = bank_reg;

  // ----------------------------------------
  // return stack
  // ----------------------------------------
  // shift deeper on push, toward level one on pop
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < `CRF_STACK_LEVELS; i++) stack_reg[i] <= '0;
      depth_reg <= `CRF_DEPTH_EMPTY;
    end else if (doPush) begin
      for (int i = `CRF_STACK_LEVELS - 1; i > 0; i--) stack_reg[i] <= stack_reg[i-1];
      stack_reg[0] <= pc_reg;
      if (depth_reg != `CRF_DEPTH_FULL) depth_reg <= 3'(depth_reg + 3'h1);
    end else if (doPop && depth_reg != `CRF_DEPTH_EMPTY) begin
      for (int i = 0; i < `CRF_STACK_LEVELS - 1; i++) stack_reg[i] <= stack_reg[i+1];
      stack_reg[`CRF_STACK_LEVELS-1] <= '0;
      depth_reg <= 3'(depth_reg - 3'h1);
    end
  end

  assign stackDepth = depth_reg;

  // ----------------------------------------
  // flag contexts
  // ----------------------------------------
  // context switch with two levels of history
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctx_reg      <= crf_pkg::CTX_NMI;
      ctxPrev1_reg <= crf_pkg::CTX_NORMAL;
      ctxPrev2_reg <= crf_pkg::CTX_NORMAL;
    end else if (pcOp == crf_pkg::PC_IRQ) begin
      ctx_reg      <= irqIsNmi ? crf_pkg::CTX_NMI : crf_pkg::CTX_INT;
      ctxPrev1_reg <= ctx_reg;
      ctxPrev2_reg <= ctxPrev1_reg;
    end else if (pcOp == crf_pkg::PC_INTERRUPT_EXIT) begin
      ctx_reg      <= ctxPrev1_reg;
      ctxPrev1_reg <= ctxPrev2_reg;
      ctxPrev2_reg <= crf_pkg::CTX_NORMAL;
    end
  end

  // flag pairs; only the active pair updates
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      carryNormal_reg    <= 1'b0;
      zeroNormal_reg     <= 1'b0;
      carryInterrupt_reg <= 1'b0;
      zeroInterrupt_reg  <= 1'b0;
      carryNmi_reg       <= 1'b0;
      zeroNmi_reg        <= 1'b0;
    end else begin
      unique case (ctx_reg)
        crf_pkg::CTX_NORMAL: begin
          if (carryWe) carryNormal_reg <= carryIn;
          if (zeroWe)  zeroNormal_reg  <= zeroIn;
        end
        crf_pkg::CTX_INT: begin
          if (carryWe) carryInterrupt_reg <= carryIn;
          if (zeroWe)  zeroInterrupt_reg  <= zeroIn;
        end
        crf_pkg::CTX_NMI: begin
          if (carryWe) carryNmi_reg <= carryIn;
          if (zeroWe)  zeroNmi_reg  <= zeroIn;
        end
        default: ;
      endcase
    end
  end

  // active pair to the alu, carry feeds rotate-left
  always_comb begin
    carryOut = carryNmi_reg;
    zeroOut  = zeroNmi_reg;
    unique case (ctx_reg)
      crf_pkg::CTX_NORMAL: begin carryOut = carryNormal_reg;    zeroOut = zeroNormal_reg;    end
      crf_pkg::CTX_INT:    begin carryOut = carryInterrupt_reg; zeroOut = zeroInterrupt_reg; end
      crf_pkg::CTX_NMI:    begin carryOut = carryNmi_reg;       zeroOut = zeroNmi_reg;       end
      default: ;
    endcase
  end

  assign ctxValue = ctx_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_push_live;
    doPush && depth_reg != `CRF_DEPTH_FULL;
  endsequence
  sequence s_pop_live;
    doPop && depth_reg != `CRF_DEPTH_EMPTY;
  endsequence

  a_reset_vector: assert property (disable iff (1'b0) !resetn |=> pc_reg == 12'hFFE && depth_reg == 3'h0)
    else $error("reset did not load vector and clear stack");
  a_nmi_after_reset: assert property (disable iff (1'b0) !resetn ##1 resetn |-> ctx_reg == crf_pkg::CTX_NMI)
    else $error("not in nmi context after reset");
  a_pc_increment: assert property (pcOp == crf_pkg::PC_INCR |=> pc_reg == 12'($past(pc_reg) + 12'h001))
    else $error("pc did not increment");
  a_branch_sum: assert property (pcOp == crf_pkg::PC_BRANCH
      |=> pc_reg == 12'($past(pc_reg) + {{4{$past(branchOffset[7])}}, $past(branchOffset)}))
    else $error("branch target wrong");
  a_push_level: assert property (s_push_live |=> stack_reg[0] == $past(pc_reg)
      && stack_reg[1] == $past(stack_reg[0]) && depth_reg == 3'($past(depth_reg) + 3'h1))
    else $error("push did not shift stack");
  a_stack_saturate: assert property (doPush && depth_reg == `CRF_DEPTH_FULL
      |=> depth_reg == 3'h6 && stack_reg[5] == $past(stack_reg[4]))
    else $error("stack left deepest state");
  a_pop_order: assert property (s_pop_live |=> pc_reg == $past(stack_reg[0])
      && stack_reg[0] == $past(stack_reg[1]))
    else $error("pop order wrong");
  a_empty_return: assert property (doPop && depth_reg == `CRF_DEPTH_EMPTY
      |=> depth_reg == 3'h0 && pc_reg == 12'($past(pc_reg) + 12'h001))
    else $error("return on empty stack misbehaved");
  a_flag_retain: assert property (ctx_reg != crf_pkg::CTX_NORMAL |=> $stable(carryNormal_reg) && $stable(zeroNormal_reg))
    else $error("normal flags changed outside own context");
  a_ctx_restore: assert property (pcOp == crf_pkg::PC_IRQ ##1 pcOp == crf_pkg::PC_INTERRUPT_EXIT
      |=> ctx_reg == $past(ctx_reg, 2))
    else $error("context not restored on exit");
  a_mirror_read: assert property (dsRdEn && dsAddr == `CRF_ADDR_PTR_SECOND |=> dsRdData == $past(ptrSecond_reg))
    else $error("mirror read wrong");
  a_acc_write: assert property (dsWrEn && !accWrEn && dsAddr == `CRF_ADDR_ACC |=> accValue == $past(dsWrData))
    else $error("accumulator bus write lost");
  // loads, selects and flag writes checked on internal registers and outputs
  a_jump_target: assert property (pcOp == crf_pkg::PC_JUMP_ABSOLUTE |=> pc_reg == $past(pcTarget))
    else $error("jump did not load target");
  a_irq_context: assert property (pcOp == crf_pkg::PC_IRQ
      |=> ctx_reg == ($past(irqIsNmi) ? crf_pkg::CTX_NMI : crf_pkg::CTX_INT)) else $error("interrupt entry context wrong");
  a_ind_pointer: assert property (dsWrEn && dsAddr == `CRF_ADDR_PTR_FIRST
      ##1 !indSel |-> indAddr == $past(dsWrData)) else $error("indirect address not from first pointer");
  a_flag_write: assert property (carryWe && ctx_reg == crf_pkg::CTX_INT
      |=> carryInterrupt_reg == $past(carryIn)) else $error("interrupt carry not written");
  a_unmapped_read: assert property (dsRdEn && !dsHit |=> dsRdData == 8'h00)
    else $error("unmapped read not zero");
  a_bank_write: assert property (bankWrEn |=> progBank == $past(bankWrData))
    else $error("bank switch write lost");

endmodule : crf_core_regs

// >>> crf_prog_mem.sv
// program memory model that feeds jump and call targets to the core
`timescale 1ns/1ps
module crf_prog_mem (
  // fetch side
  input  wire logic [11:0] fetchAddr,
  output logic      [11:0] fetchWord
);
  // scrambled contents over the whole 12-bit reach
  always_comb fetchWord = {fetchAddr[4:0], fetchAddr[11:5]} ^ 12'hA5C;
endmodule : crf_prog_mem

// >>> crf_core_regs_tb.sv
// self-checking bench for core registers, flags, pc and return stack
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_core_regs_tb;
  // ----------------------------------------
  // design signals
  // ----------------------------------------
  logic                ref_clk, resetn, dsWrEn, dsRdEn, dsHit, accWrEn, indSel, irqIsNmi, bankWrEn;
  logic                carryWe, carryIn, zeroWe, zeroIn, carryOut, zeroOut;
  logic [7:0]          dsAddr, dsWrData, dsRdData, accWrData, accValue, indAddr, branchOffset;
  logic [11:0]         pcTarget, irqVector, pcValue, memWord;
  logic [3:0]          bankWrData, progBank;
  logic [2:0]          stackDepth;
  crf_pkg::crf_pc_op_t pcOp;
  crf_pkg::crf_ctx_t   ctxValue;
  // ----------------------------------------
  // bench state and reference model
  // ----------------------------------------
  int                  numErrors, samplesChecked, cycles, seed;
  int                  mem[256];
  int                  mPc, mCtx, mRd, mBank;
  int                  mHist[2], mCar[3], mZer[3];
  int                  mStk[$];
  logic [7:0]          addrs[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};

  crf_core_regs dut (.ref_clk(ref_clk), .resetn(resetn), .dsAddr(dsAddr), .dsWrEn(dsWrEn),
    .dsWrData(dsWrData), .dsRdEn(dsRdEn), .dsHit(dsHit), .dsRdData(dsRdData), .accWrEn(accWrEn),
    .accWrData(accWrData), .accValue(accValue), .indSel(indSel), .indAddr(indAddr), .pcOp(pcOp),
    .pcTarget(pcTarget), .branchOffset(branchOffset), .irqVector(irqVector), .irqIsNmi(irqIsNmi),
    .pcValue(pcValue), .bankWrEn(bankWrEn), .bankWrData(bankWrData), .progBank(progBank),
    .carryWe(carryWe), .carryIn(carryIn), .zeroWe(zeroWe), .zeroIn(zeroIn), .carryOut(carryOut),
    .zeroOut(zeroOut), .ctxValue(ctxValue), .stackDepth(stackDepth));
  crf_prog_mem mem0 (.fetchAddr(pcValue), .fetchWord(memWord));

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      numErrors++;
      close_out();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : close_out

  task chk(input string nm, input int exp, input logic [11:0] got);
    begin
      samplesChecked++;
      if (got !== 12'(exp)) begin
        numErrors++;
        $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
    end
  endtask : chk

  function automatic bit isHit(input logic [7:0] a);
    return a inside {`CRF_ADDR_PTR_FIRST, `CRF_ADDR_PTR_SECOND, `CRF_ADDR_SD_FIRST, `CRF_ADDR_SD_SECOND,
      `CRF_ADDR_ACC};
  endfunction : isHit

  task mReset;
    begin
      foreach (mem[i]) mem[i] = 0;
      mPc = 'hFFE;
      mCtx = 2;
      mHist = '{0, 0};
      mCar = '{0, 0, 0};
      mZer = '{0, 0, 0};
      mRd = 0;
      mBank = 0;
      mStk.delete();
    end
  endtask : mReset

  // mode 0 random op, 1 forced call, 2 forced subroutine exit
  task step(input int mode);
    logic [31:0] r1, r2;
    int          np;
    begin
      @(negedge ref_clk);
      chk("pcValue", mPc, pcValue);
      chk("stackDepth", mStk.size(), stackDepth);
      chk("ctxValue", mCtx, ctxValue);
      chk("accValue", mem[255], accValue);
      chk("dsRdData", mRd, dsRdData);
      chk("progBank", mBank, progBank);
      chk("carryOut", mCar[mCtx], carryOut);
      chk("zeroOut", mZer[mCtx], zeroOut);
      r1 = $random(seed);
      r2 = $random(seed);
      dsAddr = (r1[2:0] < 3'd5) ? addrs[r1[2:0]] : r1[15:8];
      {dsWrEn, dsRdEn, indSel} = r1[5:3];
      accWrEn = r1[6] & r1[7];
      dsWrData = r1[23:16];
      accWrData = r1[31:24];
      pcOp = crf_pkg::crf_pc_op_t'(mode == 1 ? 3'd2 : mode == 2 ? 3'd5 : r2[2:0]);
      pcTarget = memWord;
      branchOffset = r2[10:3];
      irqVector = r2[22:11];
      {irqIsNmi, bankWrEn, bankWrData} = r2[28:23];
      {carryWe, carryIn, zeroWe} = r2[31:29];
      zeroIn = r1[8];
      #1;
      chk("dsHit", isHit(dsAddr), dsHit);
      chk("indAddr", mem[indSel ? 129 : 128], indAddr);
      // reference update for the coming edge
      if (dsRdEn) mRd = isHit(dsAddr) ? mem[dsAddr] : 0;
      if (dsWrEn && isHit(dsAddr) && !(dsAddr == 8'hFF && accWrEn)) mem[dsAddr] = dsWrData;
      if (accWrEn) mem[255] = accWrData;
      if (bankWrEn) mBank = bankWrData;
      if (carryWe) mCar[mCtx] = carryIn;
      if (zeroWe) mZer[mCtx] = zeroIn;
      np = mPc + 1;
      case (pcOp)
        crf_pkg::PC_JUMP_ABSOLUTE: np = pcTarget;
        crf_pkg::PC_BRANCH: np = mPc + int'($signed(branchOffset));
        crf_pkg::PC_HOLD: np = mPc;
        crf_pkg::PC_CALL, crf_pkg::PC_IRQ: begin
          mStk.push_front(mPc);
          if (mStk.size() > 6) void'(mStk.pop_back());
          np = (pcOp == crf_pkg::PC_CALL) ? pcTarget : irqVector;
          if (pcOp == crf_pkg::PC_IRQ) begin
            mHist[1] = mHist[0];
            mHist[0] = mCtx;
            mCtx = irqIsNmi ? 2 : 1;
          end
        end
        crf_pkg::PC_SUBROUTINE_EXIT, crf_pkg::PC_INTERRUPT_EXIT: begin
          if (mStk.size() > 0) np = mStk.pop_front();
          if (pcOp == crf_pkg::PC_INTERRUPT_EXIT) begin
            mCtx = mHist[0];
            mHist[0] = mHist[1];
            mHist[1] = 0;
          end
        end
        default: np = mPc + 1;
      endcase
      mPc = np & 'hFFF;
    end
  endtask : step

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hdd87;
    {numErrors, samplesChecked, cycles} = '0;
    {resetn, dsWrEn, dsRdEn, accWrEn, indSel, irqIsNmi, bankWrEn, carryWe, carryIn, zeroWe, zeroIn} = '0;
    {dsAddr, dsWrData, accWrData, branchOffset, pcTarget, irqVector, bankWrData} = '0;
    pcOp = crf_pkg::PC_HOLD;  // idle op so the release edge leaves pc at the reset vector
    mReset();
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    step(1); // first compares see the reset state
    repeat (8) step(1);
    repeat (9) step(2);
    repeat (1500) step(0);
    @(negedge ref_clk);
    resetn = 1'b0;
    // idle strobes and ops so the release edge changes nothing
    {dsWrEn, dsRdEn, accWrEn, bankWrEn, carryWe, zeroWe} = '0;
    pcOp = crf_pkg::PC_HOLD;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    mReset();
    repeat (1500) step(0);
    close_out();
  end
endmodule : crf_core_regs_tb
